// >>> shared/dmra_pkg.sv
package dmra_pkg;
  localparam int DMRA_CA_W = 10;
  localparam int DMRA_DQ_W = 32;
  localparam int DMRA_DQS_W = 4;
  localparam int DMRA_BURST = 4;
  localparam logic [3:0] DMRA_RL = 4'h3;
  localparam logic [3:0] DMRA_WL = 4'h1;
  localparam logic [3:0] DMRA_DQSCK_CK = 4'h1;
  localparam logic [3:0] DMRA_TMRR = 4'h2;
  localparam logic [3:0] DMRA_TMRW = 4'h5;
  localparam logic [7:0] DMRA_MR_TEMP = 8'h04;
  localparam logic [7:0] DMRA_MR_CAL_A = 8'h20;
  localparam logic [7:0] DMRA_MR_CAL_B = 8'h28;
  localparam logic [7:0] DMRA_MR_RESET = 8'h3F;
  localparam logic [7:0] DMRA_MR_USER = 8'h01;
  localparam logic [7:0] DMRA_USER_RST = 8'h00;
  localparam logic [7:0] DMRA_TEMP_RST = 8'h03;
  localparam logic [3:0] DMRA_CAL_A_PAT = 4'h5;
  localparam logic [3:0] DMRA_CAL_B_PAT = 4'hC;
  localparam int DMRA_CLK_MHZ = 200;
  localparam int DMRA_TSI_MS = 32;
  localparam int DMRA_TSI_CYC = DMRA_TSI_MS * DMRA_CLK_MHZ * 1000;
  localparam int DMRA_TINIT4_CYC = 16;
  // Read-to-write and read-to-write-register spacing in clocks
  localparam logic [5:0] DMRA_MRR_MRW_GAP = 6'(DMRA_RL + DMRA_DQSCK_CK + DMRA_BURST / 2 + 1);
  localparam logic [5:0] DMRA_MRR_WR_GAP = 6'(DMRA_MRR_MRW_GAP + DMRA_WL);
  localparam logic [2:0] DMRA_OP_MRR = 3'h1;
  localparam logic [2:0] DMRA_OP_MRW = 3'h2;
  localparam logic [2:0] DMRA_OP_ACT = 3'h3;
  localparam logic [2:0] DMRA_OP_PRE = 3'h4;
  localparam logic [7:0] DMRA_CMD_OFF = 8'h00;
  localparam logic [7:0] DMRA_STAT_OFF = 8'h04;
endpackage

// >>> shared/dmra_if.sv
`timescale 1ns/1ps
interface dmra_if;
  import dmra_pkg::*;
  logic cs_n;
  logic [DMRA_CA_W-1:0] ca_rise;
  logic [DMRA_CA_W-1:0] ca_fall;
  logic [DMRA_DQ_W-1:0] dq;
  logic [DMRA_DQS_W-1:0] dqs;
  logic dq_oe;
  modport ctrl (output cs_n, output ca_rise, output ca_fall, input dq, input dqs, input dq_oe);
  modport dram (input cs_n, input ca_rise, input ca_fall, output dq, output dqs, output dq_oe);
endinterface

// >>> verilog/dmra_dram.sv
`timescale 1ns/1ps
module dmra_dram
  import dmra_pkg::*;
#(
  parameter int TSI_CYC = DMRA_TSI_CYC
)(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  dmra_if.dram link,
  input wire logic [7:0] temp_sense_in,
  output logic [7:0] user_reg_out,
  output logic banks_active_out,
  output logic initializing_out
);
  import dmra_pkg::*;
  typedef struct packed {
    logic [7:0] user;
    logic [7:0] temp;
    logic [31:0] tsi_cnt;
    logic active;
    logic [4:0] init_cnt;
    logic [3:0] lat;
    logic [2:0] beat;
    logic busy;
    logic [7:0] rdata;
    logic [1:0] cal;
    logic [31:0] dq;
    logic [3:0] dqs;
    logic oe;
  } dmra_dram_s;
  dmra_dram_s s_q, s_d;
  logic [7:0] ma;
  logic is_mrr, is_mrw;
  logic [7:0] sel;
  logic bit_v;
  assign ma = {link.ca_rise[9:4], link.ca_fall[1:0]};
  assign is_mrr = !link.cs_n && link.ca_rise[3:0] == 4'h8;
  assign is_mrw = !link.cs_n && link.ca_rise[3:0] == 4'h0;
  always_comb
  begin
    s_d = s_q;
    sel = 8'h00;
    bit_v = 1'b0;
    if (s_q.tsi_cnt >= 32'(TSI_CYC - 1))
    begin
      s_d.tsi_cnt = 32'h0;
      s_d.temp = temp_sense_in;
    end
    else
      s_d.tsi_cnt = s_q.tsi_cnt + 32'h1;
    // Bank state is tracked only coarsely via ACT on CA1..0 and PRE on CA3..0
    if (!link.cs_n && link.ca_rise[1:0] == 2'h2)
      s_d.active = 1'b1;
    if (!link.cs_n && link.ca_rise[3:0] == 4'hB)
      s_d.active = 1'b0;
    if (s_q.init_cnt != 5'h0)
      s_d.init_cnt = s_q.init_cnt - 5'h1;
    else if (is_mrr && !s_q.busy)
    begin
      case (ma)
        DMRA_MR_TEMP: sel = s_q.temp;
        DMRA_MR_USER: sel = s_q.user;
        default: sel = 8'h00;
      endcase
      s_d.rdata = sel;
      s_d.cal = (ma == DMRA_MR_CAL_A) ? 2'h1 : (ma == DMRA_MR_CAL_B) ? 2'h2 : 2'h0;
      s_d.busy = 1'b1;
      s_d.lat = DMRA_RL;
      s_d.beat = 3'h0;
    end
    else if (is_mrw && !s_q.active)
    begin
      if (ma == DMRA_MR_RESET)
      begin
        s_d.user = DMRA_USER_RST;
        s_d.temp = DMRA_TEMP_RST;
        s_d.init_cnt = 5'(DMRA_TINIT4_CYC);
      end
      else if (ma == DMRA_MR_USER)
        s_d.user = link.ca_fall[9:2];
      // Writes to any other address, all read-only here, change nothing
    end
    s_d.oe = 1'b0;
    s_d.dq = 32'h0;
    s_d.dqs = 4'h0;
    if (s_q.busy && s_q.lat != 4'h0)
      s_d.lat = s_q.lat - 4'h1;
    else if (s_q.busy)
    begin
      // One beat per clock: beat index steps by one each cycle
      s_d.oe = 1'b1;
      s_d.dqs = (s_q.beat[1]) ? 4'h0 : 4'hF;
      case (s_q.cal)
        // Pattern bit n goes out on beat n
        2'h1: bit_v = DMRA_CAL_A_PAT[s_q.beat[1:0]];
        2'h2: bit_v = DMRA_CAL_B_PAT[s_q.beat[1:0]];
        default: bit_v = 1'b0;
      endcase
      if (s_q.cal != 2'h0)
        s_d.dq = {32{bit_v}};
      else if (s_q.beat == 3'h0)
        s_d.dq = {24'h0, s_q.rdata};
      else
        s_d.dq = 32'h0;
      s_d.beat = s_q.beat + 3'h1;
      if (s_q.beat == 3'(DMRA_BURST - 1))
        s_d.busy = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
      s_q.temp <= DMRA_TEMP_RST;
    end
    else
      s_q <= s_d;
  end
  assign link.dq = s_q.dq;
  assign link.dqs = s_q.dqs;
  assign link.dq_oe = s_q.oe;
  assign user_reg_out = s_q.user;
  assign banks_active_out = s_q.active;
  assign initializing_out = s_q.init_cnt != 5'h0;
endmodule

// >>> verilog/dmra_ctrl.sv
`timescale 1ns/1ps
module dmra_ctrl
  import dmra_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  dmra_if.ctrl link,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import dmra_pkg::*;
  localparam logic [7:0] CMD_OFF = DMRA_CMD_OFF;
  localparam logic [7:0] STAT_OFF = DMRA_STAT_OFF;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CAP} dmra_st_e;
  typedef struct packed {
    logic aw, w;
    logic [7:0] awa;
    logic [31:0] wd;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic cs_n;
    logic [9:0] car, caf;
    logic [5:0] gap;
    logic [3:0] cnt;
    logic [7:0] res;
    logic done;
    logic [2:0] op;
    logic [7:0] ma, wdat;
    logic go;
    logic act;
    dmra_st_e st;
  } dmra_ctrl_s;
  dmra_ctrl_s s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.cs_n = 1'b1;
    s_d.car = 10'h0;
    s_d.caf = 10'h0;
    if (s_q.gap != 6'h0)
      s_d.gap = s_q.gap - 6'h1;
    if (s_axi_awvalid_in && !s_q.aw)
    begin
      s_d.aw = 1'b1;
      s_d.awa = s_axi_awaddr_in[7:0];
    end
    if (s_axi_wvalid_in && !s_q.w)
    begin
      s_d.w = 1'b1;
      s_d.wd = s_axi_wdata_in;
    end
    if (s_q.aw && s_q.w && !s_q.bv)
    begin
      s_d.aw = 1'b0;
      s_d.w = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = 2'h0;
      if (s_q.awa == CMD_OFF && s_q.st == ST_IDLE && !s_q.go && s_axi_wstrb_in != 4'h0)
      begin
        s_d.go = 1'b1;
        s_d.op = s_q.wd[26:24];
        s_d.ma = s_q.wd[15:8];
        s_d.wdat = s_q.wd[7:0];
        s_d.done = 1'b0;
      end
      else if (s_q.awa != CMD_OFF)
        s_d.br = 2'h2;
    end
    if (s_q.bv && s_axi_bready_in)
      s_d.bv = 1'b0;
    // Software polls the command status through this read path
    if (s_axi_arvalid_in && !s_q.rv)
    begin
      s_d.rv = 1'b1;
      s_d.rr = (s_axi_araddr_in[7:0] == STAT_OFF || s_axi_araddr_in[7:0] == CMD_OFF) ? 2'h0 : 2'h2;
      s_d.rd = (s_axi_araddr_in[7:0] == STAT_OFF) ?
        {22'h0, s_q.done, s_q.st != ST_IDLE || s_q.go, s_q.res} : 32'h0;
    end
    if (s_q.rv && s_axi_rready_in)
      s_d.rv = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        if (s_q.go && s_q.gap == 6'h0)
        begin
          s_d.go = 1'b0;
          s_d.cs_n = 1'b0;
          case (s_q.op)
            DMRA_OP_MRR:
            begin
              // Calibration reads are dropped, not queued, while a row is open
              if (s_q.act && (s_q.ma == DMRA_MR_CAL_A || s_q.ma == DMRA_MR_CAL_B))
              begin
                s_d.cs_n = 1'b1;
                s_d.done = 1'b1;
              end
              else
              begin
                s_d.car = {s_q.ma[7:2], 4'h8};
                s_d.caf = {8'h0, s_q.ma[1:0]};
                s_d.cnt = DMRA_RL;
                s_d.gap = DMRA_MRR_WR_GAP;
                s_d.st = ST_WAIT;
              end
            end
            DMRA_OP_MRW:
            begin
              if (s_q.act)
              begin
                s_d.cs_n = 1'b1;
                s_d.done = 1'b1;
              end
              else
              begin
                s_d.car = {s_q.ma[7:2], 4'h0};
                s_d.caf = {s_q.wdat, s_q.ma[1:0]};
                // Reset write holds the bus for the init wait
                s_d.gap = (s_q.ma == DMRA_MR_RESET) ? 6'(DMRA_TINIT4_CYC) : 6'(DMRA_TMRW);
                s_d.done = 1'b1;
              end
            end
            DMRA_OP_ACT:
            begin
              s_d.car = 10'h2;
              s_d.act = 1'b1;
              s_d.done = 1'b1;
            end
            DMRA_OP_PRE:
            begin
              s_d.car = 10'hB;
              s_d.act = 1'b0;
              s_d.done = 1'b1;
            end
            // No array read or write is ever issued, so their spacing holds trivially
            default:
            begin
              s_d.cs_n = 1'b1;
              s_d.done = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        // NOPs only until the burst is captured
        if (s_q.cnt == 4'h0)
          s_d.st = ST_CAP;
        else
          s_d.cnt = s_q.cnt - 4'h1;
      end
      ST_CAP:
      begin
        if (link.dq_oe)
        begin
          s_d.res = link.dq[7:0];
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end
  assign link.cs_n = s_q.cs_n;
  assign link.ca_rise = s_q.car;
  assign link.ca_fall = s_q.caf;
  assign s_axi_awready_out = !s_q.aw;
  assign s_axi_wready_out = !s_q.w;
  assign s_axi_bvalid_out = s_q.bv;
  assign s_axi_bresp_out = s_q.br;
  assign s_axi_arready_out = !s_q.rv;
  assign s_axi_rvalid_out = s_q.rv;
  assign s_axi_rdata_out = s_q.rd;
  assign s_axi_rresp_out = s_q.rr;
endmodule

// >>> sim/dmra_link_sva.sv
`timescale 1ns/1ps
module dmra_link_sva
  import dmra_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic cs_n,
  input wire logic [DMRA_CA_W-1:0] ca_rise,
  input wire logic [DMRA_CA_W-1:0] ca_fall,
  input wire logic [DMRA_DQ_W-1:0] dq,
  input wire logic [DMRA_DQS_W-1:0] dqs,
  input wire logic dq_oe
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic mrr;
  logic mrw;
  logic [7:0] ma;
  logic [7:0] ma_q;
  logic act_q;
  assign mrr = !cs_n && ca_rise[3:0] == 4'h8;
  assign mrw = !cs_n && ca_rise[3:0] == 4'h0;
  assign ma = {ca_rise[9:4], ca_fall[1:0]};
  // Remembers which register the burst on the wire belongs to
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in) ma_q <= 8'h00;
    else if (mrr) ma_q <= ma;
  // Bank state as seen on the bus, to police commands that need idle banks
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in) act_q <= 1'b0;
    else if (!cs_n && ca_rise[1:0] == 2'h2) act_q <= 1'b1;
    else if (!cs_n && ca_rise[3:0] == 4'hB) act_q <= 1'b0;
  property p_mrw_idle; mrw |-> !act_q; endproperty
  a_mrw_idle: assert property (p_mrw_idle) else $error("register write with banks active");
  property p_cal_idle; mrr && (ma == DMRA_MR_CAL_A || ma == DMRA_MR_CAL_B) |-> !act_q; endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("calibration read with banks active");
  property p_mrr_lat; mrr |-> ##[4:5] $rose(dq_oe); endproperty
  a_mrr_lat: assert property (p_mrr_lat) else $error("read burst late");
  property p_burst; $rose(dq_oe) |-> dq_oe [*4] ##1 !dq_oe; endproperty
  a_burst: assert property (p_burst) else $error("burst not four beats");
  property p_strobe; $rose(dq_oe) |-> ##3 dqs != $past(dqs, 3); endproperty
  a_strobe: assert property (p_strobe) else $error("strobes idle in burst");
  property p_cal_a; $rose(dq_oe) && ma_q == DMRA_MR_CAL_A |-> dq == '1 ##1 dq == '0 ##1 dq == '1 ##1 dq == '0; endproperty
  a_cal_a: assert property (p_cal_a) else $error("pattern a wrong");
  property p_cal_b; $rose(dq_oe) && ma_q == DMRA_MR_CAL_B |-> dq == '0 ##1 dq == '0 ##1 dq == '1 ##1 dq == '1; endproperty
  a_cal_b: assert property (p_cal_b) else $error("pattern b wrong");
  property p_mrr_nop; mrr |=> cs_n; endproperty
  a_mrr_nop: assert property (p_mrr_nop) else $error("command in read period");
  property p_mrr_mrw; mrr |=> !mrw [*6]; endproperty
  a_mrr_mrw: assert property (p_mrr_mrw) else $error("write too soon after read");
  property p_mrw_nop; mrw |=> cs_n [*4]; endproperty
  a_mrw_nop: assert property (p_mrw_nop) else $error("command in write period");
  property p_rst_nop; mrw && ma == DMRA_MR_RESET |=> cs_n [*8]; endproperty
  a_rst_nop: assert property (p_rst_nop) else $error("command in init wait");
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  import dmra_pkg::*;
  // Short sensor period keeps the run brief
  localparam int TSI = 100;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, st;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] temp = 8'h05;
  logic [7:0] user_reg;
  logic banks_act, init_busy;
  int bad_count = 0;
  int num_checks = 0;
  dmra_if link();
  dmra_ctrl i_dmra_ctrl (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  dmra_dram #(.TSI_CYC(TSI)) i_dmra_dram (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link),
    .temp_sense_in(temp), .user_reg_out(user_reg), .banks_active_out(banks_act),
    .initializing_out(init_busy));
  dmra_link_sva i_dmra_link_sva (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .cs_n(link.cs_n),
    .ca_rise(link.ca_rise), .ca_fall(link.ca_fall), .dq(link.dq), .dqs(link.dqs), .dq_oe(link.dq_oe));
  always #2.5 sys_clk_in = ~sys_clk_in;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task axi_rd(input logic [31:0] a, input logic [1:0] er);
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    st = rdata;
    chk(rresp, er);
  endtask
  // Polls status until the command is done; the poll count bounds a stuck engine
  task cmd(input logic [2:0] op, input logic [7:0] ma, input logic [7:0] d);
    int n;
    n = 0;
    axi_wr({24'h0, DMRA_CMD_OFF}, {5'h00, op, 8'h00, ma, d}, 2'b00);
    do
    begin
      axi_rd({24'h0, DMRA_STAT_OFF}, 2'b00);
      n++;
    end
    while ((st[8] !== 1'b0 || st[9] !== 1'b1) && n < 100);
    // Still busy at the poll limit means a stuck engine
    chk(st[9:8], 2'b10);
  endtask
  task mrr(input logic [7:0] ma, input logic [7:0] exp);
    cmd(DMRA_OP_MRR, ma, 8'h00);
    chk(st[7:0], exp);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    $display("unexpected at %0t: watchdog expired", $time);
    bad_count++;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    mrr(DMRA_MR_CAL_A, 8'hFF);
    mrr(DMRA_MR_CAL_B, 8'h00);
    $display("test calibration done");
    cmd(DMRA_OP_MRW, DMRA_MR_USER, 8'hA5);
    chk(user_reg, 8'hA5);
    mrr(DMRA_MR_USER, 8'hA5);
    cmd(DMRA_OP_MRW, DMRA_MR_TEMP, 8'h77);
    // Read back before the first sensor update, so a landed write would show
    mrr(DMRA_MR_TEMP, DMRA_TEMP_RST);
    temp <= 8'h02;
    repeat (2 * TSI) @(posedge sys_clk_in);
    mrr(DMRA_MR_TEMP, 8'h02);
    $display("test register access done");
    cmd(DMRA_OP_ACT, 8'h00, 8'h00);
    chk(banks_act, 1'b1);
    mrr(DMRA_MR_USER, 8'hA5);
    chk(banks_act, 1'b1);
    cmd(DMRA_OP_MRR, DMRA_MR_CAL_A, 8'h00);
    chk(st[7:0], 8'hA5);
    cmd(DMRA_OP_MRW, DMRA_MR_USER, 8'h3C);
    chk(user_reg, 8'hA5);
    cmd(DMRA_OP_PRE, 8'h00, 8'h00);
    chk(banks_act, 1'b0);
    $display("test bank states done");
    cmd(DMRA_OP_MRW, DMRA_MR_RESET, 8'h00);
    chk(init_busy, 1'b1);
    repeat (DMRA_TINIT4_CYC) @(posedge sys_clk_in);
    chk(init_busy, 1'b0);
    chk(user_reg, DMRA_USER_RST);
    mrr(DMRA_MR_USER, DMRA_USER_RST);
    $display("test reset write done");
    axi_rd(32'h8, 2'b10);
    chk(st, 32'h0);
    axi_wr(32'h4, 32'h0, 2'b10);
    $display("test bus errors done");
    conclude;
  end
endmodule
